// File: include/hsg_pkg.sv
// constants and types of the haptic supply guard and trigger block
package hsg_pkg;
   // register addresses
   localparam logic [7:0] ADDR_CFG  = 8'h09;
   localparam logic [7:0] ADDR_THR1 = 8'h0a;
   localparam logic [7:0] ADDR_THR2 = 8'h0b;
   localparam logic [7:0] ADDR_FIRE = 8'h0c;
   // reset values
   localparam logic [7:0] RST_CFG   = 8'h00;
   localparam logic [7:0] RST_THR1  = 8'h92;
   localparam logic [7:0] RST_THR2  = 8'h8d;
   localparam logic [6:0] RST_FRSV  = 7'h00;
   // field positions of the supply config register and the fire register
   localparam int EXT_HI   = 7;
   localparam int EXT_LO   = 6;
   localparam int UVLO_HI  = 2;
   localparam int UVLO_LO  = 0;
   localparam int FIRE_BIT = 0;
   // extension enable codes
   localparam logic [1:0] EXT_OFF  = 2'h0;
   localparam logic [1:0] EXT_ONE  = 2'h1;
   localparam logic [1:0] EXT_BOTH = 2'h2;
   // undervoltage threshold in millivolts: base plus step per code
   localparam logic [11:0] UVLO_BASE_MV = 12'h9c4;
   localparam logic [11:0] UVLO_STEP_MV = 12'h064;
   // mode codes presented by the mode logic
   localparam logic [1:0] MODE_RTP  = 2'h0;
   localparam logic [1:0] MODE_SEQ  = 2'h1;
   localparam logic [1:0] MODE_DIAG = 2'h2;
   localparam logic [1:0] MODE_CAL  = 2'h3;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } hsg_state_t;
   typedef enum logic [1:0] {
      LVL_NOM = 2'b00,
      LVL_ONE = 2'b01,
      LVL_TWO = 2'b10
   } hsg_lvl_t;
endpackage

// File: include/hsg_clamp_if.sv
// carrier between the guard top and the clamp selector
`timescale 1ns/100ps
interface hsg_clamp_if;
   logic                  effect_start;
   logic [7:0]            supply_code;
   logic [1:0]            ext_en;
   logic [7:0]            thr_one;
   logic [7:0]            thr_two;
   logic [7:0]            clamp_nom;
   logic [7:0]            clamp_one;
   logic [7:0]            clamp_two;
   logic [7:0]            drive_limit;
   hsg_pkg::hsg_lvl_t     level;
   modport top (output effect_start, supply_code, ext_en, thr_one, thr_two, clamp_nom, clamp_one, clamp_two,
                input drive_limit, level);
   modport sel (input effect_start, supply_code, ext_en, thr_one, thr_two, clamp_nom, clamp_one, clamp_two,
                output drive_limit, level);
endinterface

// File: design/hsg_clamp_select.sv
// clamp choice sampled at effect start and held for the effect
`timescale 1ns/100ps
module hsg_clamp_select (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  ce,
   input  wire logic  srst,
   // link to top
   hsg_clamp_if.sel   cf
);
   typedef struct packed {
      logic [7:0]        limit;
      hsg_pkg::hsg_lvl_t level;
   } hsg_sel_t;
   localparam hsg_sel_t SEL_RST = '{limit: 8'h00, level: hsg_pkg::LVL_NOM};
   hsg_sel_t s_r;
   hsg_sel_t s_nxt;
   logic     en_one;
   logic     en_two;

   assign en_one = (cf.ext_en == hsg_pkg::EXT_ONE) || (cf.ext_en == hsg_pkg::EXT_BOTH); // see [RULE1]
   assign en_two = (cf.ext_en == hsg_pkg::EXT_BOTH); // see [RULE1]

   always_comb begin
      s_nxt = s_r;
      if (cf.effect_start) begin // see [RULE6]
         s_nxt.limit = cf.clamp_nom;
         s_nxt.level = hsg_pkg::LVL_NOM;
         if (en_one && (cf.supply_code < cf.thr_one)) begin // see [RULE4]
            s_nxt.limit = cf.clamp_one;
            s_nxt.level = hsg_pkg::LVL_ONE;
         end
         if (en_two && (cf.supply_code < cf.thr_two)) begin // see [RULE5] see [RULE15]
            s_nxt.limit = cf.clamp_two;
            s_nxt.level = hsg_pkg::LVL_TWO;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= SEL_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign cf.drive_limit = s_r.limit;
   assign cf.level       = s_r.level;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_hold;
      !(ce && cf.effect_start) |=> $stable(cf.drive_limit) && $stable(cf.level);
   endproperty
   a_hold: assert property (p_hold) else $error("clamp changed outside effect start"); // see [RULE6]

   property p_off;
      ce && cf.effect_start && (cf.ext_en == hsg_pkg::EXT_OFF) |=> cf.level == hsg_pkg::LVL_NOM;
   endproperty
   a_off: assert property (p_off) else $error("extension used while disabled"); // see [RULE1]

   property p_one;
      ce && cf.effect_start && (cf.ext_en == hsg_pkg::EXT_ONE) && (cf.supply_code < cf.thr_one)
         |=> cf.level == hsg_pkg::LVL_ONE && cf.drive_limit == $past(cf.clamp_one);
   endproperty
   a_one: assert property (p_one) else $error("first clamp not applied"); // see [RULE4]

   property p_two;
      ce && cf.effect_start && (cf.ext_en == hsg_pkg::EXT_BOTH) && (cf.supply_code < cf.thr_two)
         |=> cf.level == hsg_pkg::LVL_TWO && cf.drive_limit == $past(cf.clamp_two);
   endproperty
   a_two: assert property (p_two) else $error("second clamp not applied"); // see [RULE5] see [RULE15]
endmodule

// File: design/hsg_guard_top.sv
// supply guard and process fire registers of the haptic driver
// Notes on behaviour
// [RULE1] the top two bits of the supply config select no extension, first level only, or both levels.
// [RULE2] a supply below the undervoltage threshold turns the output stage off at once and forces standby.
// [RULE3] the low three bits pick an undervoltage threshold from 2.5 V to 3.2 V in 0.1 V steps.
// [RULE4] with the first level on and supply below threshold one, the first clamp becomes the drive limit.
// [RULE5] with the second level on and supply below threshold two (reset 141), the second clamp is used.
// [RULE6] the supply is compared with the extension thresholds only at effect start and held for the effect.
// [RULE7] software keeps threshold one above threshold two.
// [RULE8] software keeps clamp one at or above clamp two.
// [RULE9] writing one to the fire bit starts the process chosen by the mode.
// [RULE10] in sequencer mode the fire bit triggers playback of the sequencer slots.
// [RULE11] the fire bit reads one while the process runs and clears itself when it completes.
// [RULE12] writing zero to the fire bit during playback aborts it at once, unless a trigger pin event arrives in the same cycle.
// [RULE13] a trigger pin event sets the fire bit just like a software write of one.
// [RULE14] the fire bit also launches calibration or diagnostics when the mode selects them.
// [RULE15] when both levels hit, the second clamp wins over the first.
`timescale 1ns/100ps
module hsg_guard_top (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         ce,
   input  wire logic         srst,
   // register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [7:0]   reg_wdata,
   output logic [7:0]        reg_rdata,
   // supply measurement
   input  wire logic [11:0]  supply_mv,
   input  wire logic [7:0]   supply_code,
   // process control
   input  wire logic [1:0]   mode_sel,
   input  wire logic         trig_pulse,
   input  wire logic         process_done,
   input  wire logic         effect_start,
   output logic             proc_start,
   output logic             proc_abort,
   output logic             proc_busy,
   output logic             seq_play,
   output logic [1:0]        proc_mode,
   // drive stage
   input  wire logic [7:0]   nominal_clamp,
   input  wire logic [7:0]   drive_clamp_one,
   input  wire logic [7:0]   drive_clamp_two,
   output logic             output_stage_en,
   output logic             standby,
   output logic [7:0]        drive_limit,
   output logic [1:0]        clamp_level
);
   typedef struct packed {
      logic [7:0]          cfg;
      logic [7:0]          thr1;
      logic [7:0]          thr2;
      logic [6:0]          fire_rsv;
      hsg_pkg::hsg_state_t st;
      logic [1:0]          mode;
      logic [7:0]          rdata;
      logic                standby;
      logic                start;
      logic                abort;
   } hsg_main_t;
   localparam hsg_main_t MAIN_RST = '{cfg: hsg_pkg::RST_CFG, thr1: hsg_pkg::RST_THR1, thr2: hsg_pkg::RST_THR2,
                                      fire_rsv: hsg_pkg::RST_FRSV, st: hsg_pkg::ST_IDLE, mode: hsg_pkg::MODE_RTP,
                                      rdata: 8'h00, standby: 1'b1, start: 1'b0, abort: 1'b0};
   hsg_main_t   s_r;
   hsg_main_t   s_nxt;
   logic [2:0]  uvlo_sel;
   logic [11:0] uvlo_mv;
   logic        uvlo_now;
   logic        wr_fire;
   logic        fire_req;
   logic        busy;
   hsg_clamp_if cf ();

   assign uvlo_sel = s_r.cfg[hsg_pkg::UVLO_HI:hsg_pkg::UVLO_LO];
   assign uvlo_mv  = 12'(hsg_pkg::UVLO_BASE_MV + 12'(uvlo_sel) * hsg_pkg::UVLO_STEP_MV); // see [RULE3]
   assign uvlo_now = supply_mv < uvlo_mv; // see [RULE2]
   assign wr_fire  = reg_wr && (reg_addr == hsg_pkg::ADDR_FIRE);
   assign fire_req = (wr_fire && reg_wdata[hsg_pkg::FIRE_BIT]) || trig_pulse; // see [RULE9] see [RULE13]
   assign busy     = (s_r.st == hsg_pkg::ST_RUN);

   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.abort = 1'b0;
      if (reg_wr) begin
         if (reg_addr == hsg_pkg::ADDR_CFG) begin
            s_nxt.cfg = reg_wdata;
         end else if (reg_addr == hsg_pkg::ADDR_THR1) begin
            s_nxt.thr1 = reg_wdata;
         end else if (reg_addr == hsg_pkg::ADDR_THR2) begin
            s_nxt.thr2 = reg_wdata;
         end else if (reg_addr == hsg_pkg::ADDR_FIRE) begin
            s_nxt.fire_rsv = reg_wdata[7:1];
         end
      end
      if (reg_rd) begin
         if (reg_addr == hsg_pkg::ADDR_CFG) begin
            s_nxt.rdata = s_r.cfg;
         end else if (reg_addr == hsg_pkg::ADDR_THR1) begin
            s_nxt.rdata = s_r.thr1;
         end else if (reg_addr == hsg_pkg::ADDR_THR2) begin
            s_nxt.rdata = s_r.thr2;
         end else if (reg_addr == hsg_pkg::ADDR_FIRE) begin
            s_nxt.rdata = {s_r.fire_rsv, busy}; // see [RULE11]
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
      case (s_r.st)
         hsg_pkg::ST_IDLE: begin
            if (fire_req && !uvlo_now) begin // see [RULE9] see [RULE14]
               s_nxt.st      = hsg_pkg::ST_RUN;
               s_nxt.start   = 1'b1;
               s_nxt.mode    = mode_sel;
               s_nxt.standby = 1'b0;
            end
         end
         hsg_pkg::ST_RUN: begin
            if (uvlo_now) begin // see [RULE2]
               s_nxt.st    = hsg_pkg::ST_IDLE;
               s_nxt.abort = 1'b1;
            end else if (trig_pulse) begin
               s_nxt.st = hsg_pkg::ST_RUN;
            end else if (wr_fire && !reg_wdata[hsg_pkg::FIRE_BIT]) begin // see [RULE12]
               s_nxt.st    = hsg_pkg::ST_IDLE;
               s_nxt.abort = 1'b1;
            end else if (process_done) begin // see [RULE11]
               s_nxt.st = hsg_pkg::ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = hsg_pkg::ST_IDLE;
         end
      endcase
      if (uvlo_now) begin
         s_nxt.standby = 1'b1; // see [RULE2]
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= MAIN_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // clamp selector link
   assign cf.effect_start = effect_start && ce;
   assign cf.supply_code  = supply_code;
   assign cf.ext_en       = s_r.cfg[hsg_pkg::EXT_HI:hsg_pkg::EXT_LO];
   assign cf.thr_one      = s_r.thr1;
   assign cf.thr_two      = s_r.thr2;
   assign cf.clamp_nom    = nominal_clamp;
   assign cf.clamp_one    = drive_clamp_one;
   assign cf.clamp_two    = drive_clamp_two;

   hsg_clamp_select u_sel (
      .clock (clock),
      .ce    (ce),
      .srst  (srst),
      .cf    (cf.sel)
   );

   // outputs
   assign reg_rdata       = s_r.rdata;
   assign proc_start      = s_r.start;
   assign proc_abort      = s_r.abort;
   assign proc_busy       = busy;
   assign proc_mode       = s_r.mode;
   assign seq_play        = busy && (s_r.mode == hsg_pkg::MODE_SEQ); // see [RULE10]
   assign standby         = s_r.standby;
   assign output_stage_en = !s_r.standby && !uvlo_now; // see [RULE2]
   assign drive_limit     = cf.drive_limit;
   assign clamp_level     = cf.level;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   property p_uvlo_off;
      uvlo_now |-> !output_stage_en;
   endproperty
   a_uvlo_off: assert property (p_uvlo_off) else $error("stage on below threshold"); // see [RULE2]

   property p_uvlo_stby;
      ce && uvlo_now |=> standby && !proc_busy;
   endproperty
   a_uvlo_stby: assert property (p_uvlo_stby) else $error("no standby after undervoltage"); // see [RULE2]

   property p_uvlo_top;
      (uvlo_sel == 3'h7) |-> (uvlo_now == (supply_mv < 12'hc80));
   endproperty
   a_uvlo_top: assert property (p_uvlo_top) else $error("top threshold not 3.2 V"); // see [RULE3]

   property p_go_start;
      ce && wr_fire && reg_wdata[0] && !busy && !uvlo_now |=> proc_start && proc_busy ##1 !proc_start;
   endproperty
   a_go_start: assert property (p_go_start) else $error("write of one did not start"); // see [RULE9]

   property p_go_read;
      ce && reg_rd && (reg_addr == hsg_pkg::ADDR_FIRE) |=> reg_rdata[0] == $past(proc_busy);
   endproperty
   a_go_read: assert property (p_go_read) else $error("fire bit reads wrong"); // see [RULE11]

   property p_done;
      ce && busy && process_done && !trig_pulse && !uvlo_now && !wr_fire |=> !proc_busy && !proc_abort;
   endproperty
   a_done: assert property (p_done) else $error("fire bit not cleared on done"); // see [RULE11]

   property p_abort;
      ce && busy && wr_fire && !reg_wdata[0] && !trig_pulse |=> proc_abort && !proc_busy;
   endproperty
   a_abort: assert property (p_abort) else $error("clear did not abort"); // see [RULE12]

   property p_trig;
      ce && trig_pulse && !busy && !uvlo_now |=> proc_start && proc_mode == $past(mode_sel);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not fire"); // see [RULE13] see [RULE14]

   property p_seq;
      proc_busy && (proc_mode == hsg_pkg::MODE_SEQ) |-> seq_play;
   endproperty
   a_seq: assert property (p_seq) else $error("sequencer not playing"); // see [RULE10]

   c_start: cover property (ce && proc_start);
   c_abort: cover property (ce && proc_abort && !uvlo_now);
   c_uvlo:  cover property (proc_busy ##1 (uvlo_now && !output_stage_en));
endmodule

// File: testbench/hsg_host_model.sv
// host model driving the register port and the clamp inputs
`timescale 1ns/100ps
module hsg_host_model (
   // clock
   input  wire logic        clock,
   // register port
   output logic [7:0]       reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [7:0]       reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   // clamp values
   output logic [7:0]       nominal_clamp,
   output logic [7:0]       drive_clamp_one,
   output logic [7:0]       drive_clamp_two
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      nominal_clamp = 8'hff;
      drive_clamp_one = 8'h80;
      drive_clamp_two = 8'h40;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock) #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock) #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // threshold one is always above threshold two
   // threshold two is kept below 0x80 so that threshold one cannot wrap
   task automatic set_thr(input logic [7:0] t2, input logic [6:0] gap);
      wr(8'h0b, {1'b0, t2[6:0]});
      wr(8'h0a, {1'b0, t2[6:0]} + {1'b0, gap} + 8'h01);
   endtask
   // clamp one never below clamp two
   task automatic set_clamp(input logic [6:0] c2, input logic [6:0] dl);
      drive_clamp_two = {1'b0, c2};
      drive_clamp_one = {1'b0, c2} + {1'b0, dl};
   endtask
endmodule

// File: testbench/haptic_supply_guard_and_trigger_tb.sv
// self-checking bench of the supply guard and fire registers
`timescale 1ns/100ps
module haptic_supply_guard_and_trigger_tb;
   logic clock, srst, ce, trig_pulse, process_done, effect_start;
   logic [6:0] g;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, supply_code, nc, c1, c2, drive_limit, d, t1, t2;
   logic reg_wr, reg_rd, proc_start, proc_abort, proc_busy, seq_play, output_stage_en, standby;
   logic [1:0] mode_sel, proc_mode, clamp_level, lv;
   logic [11:0] supply_mv;
   logic [31:0] seed;
   int fails, checks, cyc;
   hsg_guard_top uut (.clock(clock), .ce(ce), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .supply_mv(supply_mv),
      .supply_code(supply_code), .mode_sel(mode_sel), .trig_pulse(trig_pulse), .process_done(process_done),
      .effect_start(effect_start), .proc_start(proc_start), .proc_abort(proc_abort), .proc_busy(proc_busy),
      .seq_play(seq_play), .proc_mode(proc_mode), .nominal_clamp(nc), .drive_clamp_one(c1),
      .drive_clamp_two(c2), .output_stage_en(output_stage_en), .standby(standby),
      .drive_limit(drive_limit), .clamp_level(clamp_level));
   hsg_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nominal_clamp(nc), .drive_clamp_one(c1),
      .drive_clamp_two(c2));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [1:0] exp_lvl(input logic [1:0] e, input logic [7:0] s, a, b);
      if (e == 2'h2 && s < b) return 2'h2;
      if ((e == 2'h1 || e == 2'h2) && s < a) return 2'h1;
      return 2'h0;
   endfunction
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(posedge clock) #1;
      s = 1'b1;
      @(posedge clock) #1;
      s = 1'b0;
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      seed = 32'd47;
      srst = 1'b1;
      ce = 1'b1;
      trig_pulse = 1'b0;
      process_done = 1'b0;
      effect_start = 1'b0;
      mode_sel = 2'h0;
      supply_mv = 12'hfa0;
      supply_code = 8'hff;
      repeat (5) @(posedge clock);
      #1 srst = 1'b0;
      host.rd(8'h09, d); chk(d, 8'h00);
      host.rd(8'h0a, d); chk(d, 8'h92);
      host.rd(8'h0b, d); chk(d, 8'h8d);
      host.rd(8'h0c, d); chk(d, 8'h00);
      host.rd(8'h20, d); chk(d, 8'h00);
      host.wr(8'h0c, 8'hfe);
      host.rd(8'h0c, d); chk(d, 8'hfe);
      host.wr(8'h0c, 8'h00);
      for (int i = 0; i < 6; i++) begin
         t1 = 8'(rnd());
         host.wr(8'h09 + 8'(i % 3), t1);
         host.rd(8'h09 + 8'(i % 3), d); chk(d, t1);
      end
      for (int m = 0; m < 4; m++) begin
         mode_sel = 2'(m);
         host.wr(8'h0c, 8'h01);
         chk({proc_start, proc_busy, seq_play, proc_mode}, {2'b11, m == 1, 2'(m)});
         host.rd(8'h0c, d); chk(d, 8'h01);
         pulse(process_done);
         chk(proc_busy, 1'b0);
         host.rd(8'h0c, d); chk(d, 8'h00);
      end
      mode_sel = 2'h1;
      pulse(trig_pulse);
      chk({proc_start, proc_busy, seq_play}, 3'b111);
      host.wr(8'h0c, 8'h00);
      chk({proc_abort, proc_busy, seq_play}, 3'b100);
      for (int s = 0; s < 8; s++) begin
         host.wr(8'h09, 8'(s));
         supply_mv = 12'd2500 + 12'd100 * 12'(s);
         host.wr(8'h0c, 8'h01);
         chk({output_stage_en, standby}, 2'b10);
         supply_mv = supply_mv - 12'd1;
         #1 chk(output_stage_en, 1'b0);
         @(posedge clock) #1 chk({standby, proc_busy, proc_abort}, 3'b101);
         host.wr(8'h0c, 8'h01);
         host.rd(8'h0c, d); chk(d, 8'h00);
      end
      supply_mv = 12'hfa0;
      // a write while the clock enable is low must leave the register alone
      ce = 1'b0;
      host.wr(8'h09, 8'h55);
      ce = 1'b1;
      host.rd(8'h09, d); chk(d, 8'h07);
      // reset while idle brings the registers back to their reset values
      @(posedge clock) #1 srst = 1'b1;
      @(posedge clock) #1 srst = 1'b0;
      chk({standby, output_stage_en, proc_busy}, 3'b100);
      host.rd(8'h09, d); chk(d, 8'h00);
      host.rd(8'h0a, d); chk(d, 8'h92);
      for (int i = 0; i < 16; i++) begin
         t2 = {1'b0, 7'(rnd())};
         g = 7'(rnd());
         t1 = t2 + {1'b0, g} + 8'h01;
         host.set_thr(t2, g);
         host.rd(8'h0a, d); chk(d, t1);
         host.set_clamp(7'(rnd()), 7'(rnd()));
         host.wr(8'h09, {2'(i), 6'h00});
         supply_code = (i < 4) ? t2 : (i < 8) ? t2 - 8'h01 : 8'(rnd());
         pulse(effect_start);
         lv = exp_lvl(2'(i), supply_code, t1, t2);
         d = (lv == 2'h2) ? c2 : (lv == 2'h1) ? c1 : nc;
         chk(clamp_level, lv);
         chk(drive_limit, d);
         supply_code = ~supply_code;
         host.set_clamp(7'(rnd()), 7'(rnd()));
         repeat (3) @(posedge clock);
         #1 chk(drive_limit, d);
      end
      close_out();
   end
endmodule
